/* File: boitc_defines.svh */
`ifndef BOITC_DEFINES_SVH
`define BOITC_DEFINES_SVH

// Register byte offsets
`define BOITC_OFS_CTRL 8'h00
`define BOITC_OFS_DAC0 8'h04
`define BOITC_OFS_DAC1 8'h08
`define BOITC_OFS_DIO 8'h0C
`define BOITC_OFS_STAT 8'h10

// Control register fields
`define BOITC_CTRL_REF_EXT0 0
`define BOITC_CTRL_BIPOLAR0 1
`define BOITC_CTRL_REF_EXT1 2
`define BOITC_CTRL_BIPOLAR1 3
`define BOITC_CTRL_DIR_A 4
`define BOITC_CTRL_DIR_B 5
`define BOITC_CTRL_TB_BUS 8
`define BOITC_CTRL_TB_DRIVE 9
`define BOITC_CTRL_RESET 32'h0000_0000

// Data and port reset values
`define BOITC_DAC_RESET 16'h0000
`define BOITC_DIO_RESET 8'h00

// Timebase divide ratio
`define BOITC_TB_DIVIDE 10

`endif

/* File: boitc_pkg.sv */
package boitc_pkg;

    typedef struct packed {
        logic ref_ext;
        logic bipolar;
        logic [15:0] code;
        logic signed [16:0] level;
    } boitc_dac_s;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } boitc_port_s;

endpackage

/* File: boitc_top.sv */
`timescale 1ns/1ps
`include "boitc_defines.svh"

module boitc_top
    import boitc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output boitc_dac_s [1:0] dac_o,
    input wire logic [3:0] digital_port_a_lines_i,
    output logic [3:0] digital_port_a_lines_o,
    output logic [3:0] digital_port_a_lines_oe,
    input wire logic [3:0] digital_port_b_lines_i,
    output logic [3:0] digital_port_b_lines_o,
    output logic [3:0] digital_port_b_lines_oe,
    input wire logic shared_timing_bus_clk_i,
    output logic shared_timing_bus_clk_o,
    output logic shared_timing_bus_clk_oe,
    output logic counter_source_o
);

    localparam logic [3:0] DIV_LAST = 4'(`BOITC_TB_DIVIDE - 1);
    localparam logic [3:0] DIV_HALF = 4'(`BOITC_TB_DIVIDE / 2);

    // Bus slave state
    logic [7:0] addr_r;
    logic dp_wr_r;
    logic dp_rd_r;
    logic rd_done_r;
    logic [31:0] hrdata_r;

    // Software-visible state
    logic [31:0] ctrl_r;
    logic [15:0] dac0_r;
    logic [15:0] dac1_r;
    logic [7:0] dio_out_r;

    // Pin synchronisers
    logic [7:0] dio_s1_r;
    logic [7:0] dio_s2_r;
    logic tb_s1_r;
    logic tb_s2_r;
    logic tb_s3_r;

    // Timebase divider
    logic [3:0] div_cnt_r;
    logic cnt_src_r;

    wire accept = hsel & htrans[1] & hready;
    wire rd_stall = dp_rd_r & ~rd_done_r;
    wire wr_ctrl = dp_wr_r & (addr_r == `BOITC_OFS_CTRL);
    wire wr_dac0 = dp_wr_r & (addr_r == `BOITC_OFS_DAC0);
    wire wr_dac1 = dp_wr_r & (addr_r == `BOITC_OFS_DAC1);
    wire wr_dio = dp_wr_r & (addr_r == `BOITC_OFS_DIO);

    wire sel_bus = ctrl_r[`BOITC_CTRL_TB_BUS];
    // Driving is refused while the bus clock is our source, which would loop it back
    wire drive_bus = ctrl_r[`BOITC_CTRL_TB_DRIVE] & ~sel_bus;
    wire dir_a_out = ctrl_r[`BOITC_CTRL_DIR_A];
    wire dir_b_out = ctrl_r[`BOITC_CTRL_DIR_B];

    // Received clock counts on rising edges; the local oscillator is hclk itself
    wire bus_rise = tb_s2_r & ~tb_s3_r;
    wire tb_tick = sel_bus ? bus_rise : 1'b1;
    wire div_wrap = (div_cnt_r == DIV_LAST);

    wire [3:0] port_a_view = dir_a_out ? dio_out_r[3:0] : dio_s2_r[3:0];
    wire [3:0] port_b_view = dir_b_out ? dio_out_r[7:4] : dio_s2_r[7:4];
    wire [31:0] stat_word = {24'h00_0000, div_cnt_r, 1'b0, cnt_src_r, drive_bus, sel_bus};

    wire [31:0] rd_mux =
        (addr_r == `BOITC_OFS_CTRL) ? ctrl_r :
        (addr_r == `BOITC_OFS_DAC0) ? {16'h0000, dac0_r} :
        (addr_r == `BOITC_OFS_DAC1) ? {16'h0000, dac1_r} :
        (addr_r == `BOITC_OFS_DIO) ? {24'h00_0000, port_b_view, port_a_view} :
        (addr_r == `BOITC_OFS_STAT) ? stat_word : 32'h0000_0000;

    wire [31:0] ctrl_mask = 32'h0000_0000
        | (32'h1 << `BOITC_CTRL_REF_EXT0) | (32'h1 << `BOITC_CTRL_BIPOLAR0)
        | (32'h1 << `BOITC_CTRL_REF_EXT1) | (32'h1 << `BOITC_CTRL_BIPOLAR1)
        | (32'h1 << `BOITC_CTRL_DIR_A) | (32'h1 << `BOITC_CTRL_DIR_B)
        | (32'h1 << `BOITC_CTRL_TB_BUS) | (32'h1 << `BOITC_CTRL_TB_DRIVE);

    // Reads take one wait state so that hrdata comes from a flop
    assign hreadyout = ~rd_stall;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 8'h00;
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            rd_done_r <= 1'b0;
        end else begin
            if (accept) begin
                addr_r <= haddr[7:0];
            end
            dp_wr_r <= accept & hwrite;
            dp_rd_r <= accept ? ~hwrite : rd_stall;
            rd_done_r <= rd_stall;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_stall) begin
            hrdata_r <= rd_mux;
        end
    end

    // Reset gives local timebase, bus driver off, ports as inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `BOITC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= hwdata & ctrl_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac0_r <= `BOITC_DAC_RESET;
            dac1_r <= `BOITC_DAC_RESET;
            dio_out_r <= `BOITC_DIO_RESET;
        end else begin
            if (wr_dac0) begin
                dac0_r <= hwdata[15:0];
            end
            if (wr_dac1) begin
                dac1_r <= hwdata[15:0];
            end
            if (wr_dio) begin
                dio_out_r <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dio_s1_r <= 8'h00;
            dio_s2_r <= 8'h00;
            tb_s1_r <= 1'b0;
            tb_s2_r <= 1'b0;
            tb_s3_r <= 1'b0;
        end else begin
            dio_s1_r <= {digital_port_b_lines_i, digital_port_a_lines_i};
            dio_s2_r <= dio_s1_r;
            tb_s1_r <= shared_timing_bus_clk_i;
            tb_s2_r <= tb_s1_r;
            tb_s3_r <= tb_s2_r;
        end
    end

    // Counter source is high for the first half of each ten-tick period
    // Count starts at its last value so the first pulse after reset is full length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= DIV_LAST;
            cnt_src_r <= 1'b0;
        end else if (tb_tick) begin
            div_cnt_r <= div_wrap ? 4'h0 : div_cnt_r + 4'h1;
            cnt_src_r <= div_wrap | (div_cnt_r < (DIV_HALF - 4'h1));
        end
    end

    assign counter_source_o = cnt_src_r;

    // Local oscillator goes out on the shared line only while enabled; one driver per bus
    assign shared_timing_bus_clk_o = hclk & drive_bus;
    assign shared_timing_bus_clk_oe = drive_bus;

    // Whole-port direction: all four enables follow one bit
    assign digital_port_a_lines_o = dio_out_r[3:0];
    assign digital_port_a_lines_oe = {4{dir_a_out}};
    assign digital_port_b_lines_o = dio_out_r[7:4];
    assign digital_port_b_lines_oe = {4{dir_b_out}};

    // Per-channel converter view; level is the signed value the code stands for
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_dac
            logic signed [16:0] level_r;
            wire [15:0] code = (ch == 0) ? dac0_r : dac1_r;
            wire bip = ctrl_r[`BOITC_CTRL_BIPOLAR0 + 2 * ch];
            wire ref_ext = ctrl_r[`BOITC_CTRL_REF_EXT0 + 2 * ch];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    level_r <= 17'sh0_0000;
                end else if (bip) begin
                    level_r <= {code[15], code};
                end else begin
                    level_r <= {1'b0, code};
                end
            end
            assign dac_o[ch].ref_ext = ref_ext;
            assign dac_o[ch].bipolar = bip;
            assign dac_o[ch].code = code;
            assign dac_o[ch].level = level_r;
        end
    endgenerate

endmodule

/* File: boitc_bus_peer.sv */
`timescale 1ns/1ps
// Another board's timebase; it stays still while our board drives the line
module boitc_bus_peer (
    input wire logic en,
    input wire logic other_oe,
    output logic clk
);
    initial clk = 1'b0;
    always #200 clk = (en && !other_oe) ? ~clk : 1'b0;
endmodule

/* File: boitc_monitor.sv */
`timescale 1ns/1ps
module boitc_monitor
    import boitc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire boitc_dac_s [1:0] dac_o,
    input wire logic [3:0] digital_port_a_lines_oe,
    input wire logic [3:0] digital_port_b_lines_oe,
    input wire logic shared_timing_bus_clk_oe,
    input wire logic counter_source_o
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && htrans[1] && hready;
    AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    AST_WR_ZERO: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    AST_OKAY: assert property (hresp == 1'b0) else $error("bad response");
    AST_PORT_A: assert property (digital_port_a_lines_oe inside {4'h0, 4'hF})
        else $error("port A split");
    AST_PORT_B: assert property (digital_port_b_lines_oe inside {4'h0, 4'hF})
        else $error("port B split");
    AST_DEFAULTS: assert property ($rose(hresetn) |-> !shared_timing_bus_clk_oe &&
        digital_port_a_lines_oe == 4'h0 && digital_port_b_lines_oe == 4'h0)
        else $error("bad defaults");
    AST_BIPOLAR: assert property ($past(dac_o[0].bipolar) |->
        dac_o[0].level == {$past(dac_o[0].code[15]), $past(dac_o[0].code)})
        else $error("bipolar level");
    AST_UNIPOLAR: assert property (!$past(dac_o[1].bipolar) |->
        dac_o[1].level == {1'b0, $past(dac_o[1].code)}) else $error("unipolar level");
    AST_SRC_HIGH: assert property ($rose(counter_source_o) |-> counter_source_o [*5])
        else $error("source high short");
    AST_SRC_LOW: assert property ($fell(counter_source_o) |-> !counter_source_o [*5])
        else $error("source low short");
endmodule
bind boitc_top boitc_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .dac_o(dac_o), .digital_port_a_lines_oe(digital_port_a_lines_oe),
    .digital_port_b_lines_oe(digital_port_b_lines_oe),
    .shared_timing_bus_clk_oe(shared_timing_bus_clk_oe), .counter_source_o(counter_source_o));

/* File: test_board_output_io_timebase_config.sv */
`timescale 1ns/1ps
module test_board_output_io_timebase_config;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pen = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [3:0] pa = 0, pb = 0, n;
    logic [15:0] c0, c1;
    logic [15:0] cor [4] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0000};
    wire rdy, sh_o, sh_oe, pclk, cs;
    wire [31:0] hrdata;
    wire [3:0] ao, aoe, bo, boe;
    boitc_pkg::boitc_dac_s [1:0] dac;
    int err_total = 0, compares = 0, seed = 25, i, k;
    boitc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
        .hrdata(hrdata), .hreadyout(rdy), .hresp(), .dac_o(dac), .digital_port_a_lines_i(pa),
        .digital_port_a_lines_o(ao), .digital_port_a_lines_oe(aoe),
        .digital_port_b_lines_i(pb), .digital_port_b_lines_o(bo), .digital_port_b_lines_oe(boe),
        .shared_timing_bus_clk_i(sh_oe ? sh_o : pclk), .shared_timing_bus_clk_o(sh_o),
        .shared_timing_bus_clk_oe(sh_oe), .counter_source_o(cs));
    boitc_bus_peer peer_u (.en(pen), .other_oe(sh_oe), .clk(pclk));
    initial forever #50 hclk = ~hclk;
    function logic [16:0] lvl(input logic b, input logic [15:0] c);
        return b ? {c[15], c} : {1'b0, c};
    endfunction
    task chk(input logic [39:0] g, input logic [39:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Sampling at the wake-up of the edge sees values from before the edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk iff rdy);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk iff rdy);
        q = hrdata;
    endtask
    // Window of whole divider periods, so the count is exact whatever the phase
    task cnt(input int m, input int e);
        k = 0;
        fork
            repeat (m) @(posedge hclk);
            forever @(posedge cs) k++;
        join_any
        disable fork;
        chk(40'(k), 40'(e));
    endtask
    task conclude;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #1000000;
        err_total++;
        conclude;
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(0, 8'h00, 0);
        chk(40'(q), 40'h0);
        chk({31'h0, aoe, boe, sh_oe}, 40'h0);
        for (i = 0; i < 8; i++) begin
            n = (i < 4) ? 4'(i * 5) : 4'($random(seed));
            c0 = (i < 4) ? cor[i] : 16'($random(seed));
            c1 = (i < 4) ? ~cor[i] : 16'($random(seed));
            xfer(1, 8'h00, {28'h0, n});
            xfer(1, 8'h04, {16'h0, c0});
            xfer(1, 8'h08, {16'h0, c1});
            repeat (2) @(posedge hclk);
            chk({5'h0, dac[0]}, {5'h0, n[0], n[1], c0, lvl(n[1], c0)});
            chk({5'h0, dac[1]}, {5'h0, n[2], n[3], c1, lvl(n[3], c1)});
        end
        xfer(0, 8'h04, 0);
        chk(40'(q), 40'(c0));
        pa <= 4'($random(seed));
        pb <= 4'h3;
        xfer(1, 8'h00, 32'h10);
        xfer(1, 8'h0C, 32'hA5);
        repeat (3) @(posedge hclk);
        xfer(0, 8'h0C, 0);
        chk(40'(q), 40'h35);
        chk({24'h0, ao, aoe, boe, 4'h0}, 40'h5F00);
        xfer(1, 8'h00, 32'h20);
        xfer(0, 8'h0C, 0);
        chk(40'(q), {32'h0, 4'hA, pa});
        chk({24'h0, bo, boe, aoe, 4'h0}, 40'hAF00);
        xfer(1, 8'h24, 32'hFFFF);
        xfer(0, 8'h24, 0);
        chk(40'(q), 40'h0);
        xfer(1, 8'h00, 32'h200);
        repeat (2) @(posedge hclk);
        chk(40'(sh_oe), 40'h1);
        @(negedge hclk);
        #10 chk(40'(sh_o), 40'h0);
        @(posedge hclk);
        #10 chk(40'(sh_o), 40'h1);
        @(posedge hclk);
        cnt(200, 20);
        pen <= 1'b1;
        xfer(1, 8'h00, 32'h300);
        repeat (60) @(posedge hclk);
        chk(40'(sh_oe), 40'h0);
        #10 chk(40'(sh_o), 40'h0);
        @(posedge hclk);
        xfer(0, 8'h10, 0);
        chk(40'(q[1:0]), 40'h1);
        cnt(800, 20);
        conclude;
    end
endmodule
